// file: common/rbl_pkg.sv
// Constants, types and carriers shared by the reset and boot loader.
// Functional notes
// R01 - Byte order follows the select input; default level is little endian.
// R02 - Outside: big endian (select at 0) needs the lane swap strap held low.
// R03 - Lane correction leaves little endian unchanged while the strap is 1.
// R04 - While reset input is low, every flop is held in its reset state.
// R05 - After reset release, boot runs with the selected setup and mode.
// R06 - Emulation boot: core stalls until debugger release, then fetches at 0.
// R07 - Outside: debugger sets a breakpoint at zero before releasing the core.
// R08 - ROM boot: 1 KB from region one to 0, default timing, core stalled.
// R09 - Narrow ROMs: bytes or half-words assemble into 32-bit words first.
// R10 - Copy runs as one single-frame block transfer with no core involvement.
// R11 - After the copy completes, the core leaves stall and starts at 0.
// R12 - Outside: ROM contents are stored in the selected byte order.
// R13 - Outside: reset after power-up, clock running before release.
// R14 - Boot mode and ROM width are captured once at reset release and held.
package rbl_pkg;

  localparam int CLK_MHZ = 50;
  // Default ROM strobe time; a least time, so cycles round up.
  localparam int ROM_ACCESS_NS = 300;
  localparam int ROM_ACC_CYC = (ROM_ACCESS_NS * CLK_MHZ + 999) / 1000;
  localparam int ACC_CNT_W = 5;
  localparam logic [ACC_CNT_W-1:0] ACC_LAST =
    ACC_CNT_W'(ROM_ACC_CYC - 1);

  localparam int BOOT_BYTES = 1024;
  localparam int RADDR_W = 10;
  localparam int WCNT_W = 8;
  localparam logic [WCNT_W-1:0] WCNT_LAST = WCNT_W'(BOOT_BYTES / 4 - 1);
  localparam logic [RADDR_W-1:0] ROM_START = 10'h000;
  localparam logic [RADDR_W-1:0] STEP_BYTE = 10'h001;
  localparam logic [RADDR_W-1:0] STEP_HALF = 10'h002;
  localparam logic [1:0] PARTS_LAST_8 = 2'h3;
  localparam logic [1:0] PARTS_LAST_16 = 2'h1;

  localparam logic [31:0] BOOT_DST_ADDR = 32'h0000_0000;
  localparam logic [31:0] CORE_START_ADDR = 32'h0000_0000;

  // Register map, byte addresses on the Avalon slave.
  localparam int AV_ADDR_W = 4;
  localparam logic [AV_ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [AV_ADDR_W-1:0] REG_STATUS = 4'h4;
  localparam logic [AV_ADDR_W-1:0] REG_COUNT = 4'h8;
  localparam int CTRL_RELEASE_BIT = 0;
  localparam int ST_STALL_BIT = 0;
  localparam int ST_DONE_BIT = 1;
  localparam int ST_BIG_BIT = 2;
  localparam int ST_ROMBOOT_BIT = 3;
  localparam int ST_W16_BIT = 4;
  localparam int ST_LSWAP_BIT = 5;
  localparam int ST_STATE_LSB = 8;

  typedef enum logic [2:0] {
    ST_LATCH    = 3'b000,
    ST_EMU_WAIT = 3'b001,
    ST_ROM_READ = 3'b010,
    ST_ROM_WAIT = 3'b011,
    ST_WRITE    = 3'b100,
    ST_RUN      = 3'b101
  } rbl_state_t;

  typedef struct packed {
    logic byte_order_select;
    logic bus_lane_swap_strap;
    logic rom_boot;
    logic rom_width16;
  } rbl_straps_t;

  localparam rbl_straps_t STRAPS_RST = 4'hc;

  typedef struct packed {
    logic chip_select_region_one_n;
    logic oe_n;
    logic [RADDR_W-1:0] addr;
  } rbl_rom_bus_t;

  localparam rbl_rom_bus_t ROM_BUS_IDLE = 12'hc00;

endpackage

// file: core/rbl_rom_access.sv
// One default-timed read cycle on chip select region one.
`timescale 1ns/10ps
module rbl_rom_access (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Request side
  input wire logic start,
  input wire logic [rbl_pkg::RADDR_W-1:0] addr,
  output logic done,
  output logic [15:0] data,
  // ROM pins
  output rbl_pkg::rbl_rom_bus_t rom_bus,
  input wire logic [15:0] rom_data
);

  logic busy_reg;
  logic [rbl_pkg::ACC_CNT_W-1:0] cnt_reg;

  wire last_cyc = busy_reg && (cnt_reg == rbl_pkg::ACC_LAST);

  // Fixed strobe length stands in for the reset-default ROM timing. R08
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      busy_reg <= 1'b0;
      cnt_reg <= '0;
      done <= 1'b0;
      data <= 16'h0000;
      rom_bus <= rbl_pkg::ROM_BUS_IDLE;
    end else begin
      done <= last_cyc;
      if (start && !busy_reg) begin
        busy_reg <= 1'b1;
        cnt_reg <= '0;
        rom_bus.chip_select_region_one_n <= 1'b0;
        rom_bus.oe_n <= 1'b0;
        rom_bus.addr <= addr;
      end else if (last_cyc) begin
        busy_reg <= 1'b0;
        data <= rom_data;
        rom_bus <= rbl_pkg::ROM_BUS_IDLE;
      end else if (busy_reg) begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end

endmodule

// file: core/rbl_avmm_regs.sv
// Avalon-MM slave holding the loader control and status words.
`timescale 1ns/10ps
module rbl_avmm_regs (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Avalon-MM slave
  input wire logic [rbl_pkg::AV_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Block side
  input wire logic [31:0] status_word,
  input wire logic [31:0] count_word,
  output logic release_pulse
);

  wire req = avs_read || avs_write;
  wire sel_ctrl = (avs_address == rbl_pkg::REG_CTRL);
  wire sel_status = (avs_address == rbl_pkg::REG_STATUS);
  wire sel_count = (avs_address == rbl_pkg::REG_COUNT);
  // Unmapped and write-only locations read as zero.
  wire [31:0] rd_mux = sel_status ? status_word :
                       sel_count ? count_word : 32'h0000_0000;
  // The write takes effect at the edge where waitrequest is sampled low.
  wire commit_wr = avs_write && !avs_waitrequest;
  wire rel_wr = commit_wr && sel_ctrl && avs_byteenable[0] &&
                avs_writedata[rbl_pkg::CTRL_RELEASE_BIT];

  // Every access costs exactly one wait cycle.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
      release_pulse <= 1'b0;
    end else begin
      avs_waitrequest <= !(req && avs_waitrequest);
      if (avs_read && avs_waitrequest) begin
        avs_readdata <= rd_mux;
      end
      release_pulse <= rel_wr;
    end
  end

endmodule

// file: core/rbl_boot_ctrl.sv
// Reset release, strap capture and boot copy sequencer.
//
// The placing of the registers and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/10ps
module rbl_boot_ctrl (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Configuration straps
  input wire rbl_pkg::rbl_straps_t straps,
  // Debugger release
  input wire logic emu_release,
  // Avalon-MM slave
  input wire logic [rbl_pkg::AV_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Boot ROM pins
  output rbl_pkg::rbl_rom_bus_t rom_bus,
  input wire logic [15:0] rom_data,
  // Destination memory write port
  output logic [31:0] dst_addr,
  output logic [31:0] dst_data,
  output logic dst_we,
  // Core control
  output logic core_stall,
  output logic core_start,
  output logic [31:0] core_fetch_addr,
  // Device-wide configuration
  output logic big_endian,
  output logic lane_correct
);

  rbl_pkg::rbl_state_t state_reg;
  rbl_pkg::rbl_state_t state_next;
  rbl_pkg::rbl_straps_t straps_reg;
  rbl_pkg::rbl_straps_t straps_next;
  logic [rbl_pkg::RADDR_W-1:0] raddr_reg;
  logic [rbl_pkg::RADDR_W-1:0] raddr_next;
  logic [31:0] acc_reg;
  logic [31:0] acc_next;
  logic [1:0] part_reg;
  logic [1:0] part_next;
  logic [rbl_pkg::WCNT_W-1:0] wcnt_reg;
  logic [rbl_pkg::WCNT_W-1:0] wcnt_next;
  logic [rbl_pkg::WCNT_W:0] copied_reg;
  logic [rbl_pkg::WCNT_W:0] copied_next;
  logic done_reg;
  logic done_next;
  logic core_stall_next;
  logic core_start_next;
  logic dst_we_next;
  logic [31:0] dst_addr_next;
  logic [31:0] dst_data_next;

  logic rd_done;
  logic [15:0] rd_data;
  logic sw_release;
  logic [31:0] status_word;
  logic [31:0] count_word;

  // Lane and order decode, taken from the captured straps.
  wire is_big = !straps_reg.byte_order_select; // R01
  // The strap only matters in big endian; at 1 in little endian it is inert.
  wire lanes_hi = is_big && straps_reg.bus_lane_swap_strap; // R03
  wire [7:0] byte_in = lanes_hi ? rd_data[15:8] : rd_data[7:0];
  wire w16 = straps_reg.rom_width16;
  wire [1:0] parts_last = w16 ? rbl_pkg::PARTS_LAST_16 :
                                rbl_pkg::PARTS_LAST_8;
  wire [rbl_pkg::RADDR_W-1:0] raddr_step = w16 ? rbl_pkg::STEP_HALF :
                                                 rbl_pkg::STEP_BYTE;
  wire last_part = (part_reg == parts_last);
  wire last_word = (wcnt_reg == rbl_pkg::WCNT_LAST);
  wire rd_start = (state_reg == rbl_pkg::ST_ROM_READ);
  wire release_req = emu_release || sw_release;

  // Little endian puts the first unit lowest, big endian highest. R09
  wire [31:0] acc_le8 = {byte_in, acc_reg[31:8]};
  wire [31:0] acc_be8 = {acc_reg[23:0], byte_in};
  wire [31:0] acc_le16 = {rd_data, acc_reg[31:16]};
  wire [31:0] acc_be16 = {acc_reg[15:0], rd_data};
  wire [31:0] acc_le = w16 ? acc_le16 : acc_le8;
  wire [31:0] acc_be = w16 ? acc_be16 : acc_be8;
  wire [31:0] acc_shift = is_big ? acc_be : acc_le; // R09

  wire [31:0] word_offset = {22'h000000, wcnt_reg, 2'h0};

  assign status_word = {
    21'h000000,
    state_reg,
    2'h0,
    straps_reg.bus_lane_swap_strap,
    straps_reg.rom_width16,
    straps_reg.rom_boot,
    is_big,
    done_reg,
    core_stall
  };
  assign count_word = {{(31 - rbl_pkg::WCNT_W){1'b0}}, copied_reg};

  rbl_rom_access u_rom (
    .clk(clk),
    .nrst(nrst),
    .start(rd_start),
    .addr(raddr_reg),
    .done(rd_done),
    .data(rd_data),
    .rom_bus(rom_bus),
    .rom_data(rom_data)
  );

  rbl_avmm_regs u_regs (
    .clk(clk),
    .nrst(nrst),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .status_word(status_word),
    .count_word(count_word),
    .release_pulse(sw_release)
  );

  always_comb begin
    state_next = state_reg;
    straps_next = straps_reg;
    raddr_next = raddr_reg;
    acc_next = acc_reg;
    part_next = part_reg;
    wcnt_next = wcnt_reg;
    copied_next = copied_reg;
    done_next = done_reg;
    core_stall_next = core_stall;
    core_start_next = 1'b0;
    dst_we_next = 1'b0;
    dst_addr_next = dst_addr;
    dst_data_next = dst_data;
    case (state_reg)
      rbl_pkg::ST_LATCH: begin
        // Straps are caught once at the first edge after release and then
        // held, so a pin that moves mid-boot cannot change the flow.
        straps_next = straps; // R14
        raddr_next = rbl_pkg::ROM_START;
        part_next = 2'h0;
        wcnt_next = '0;
        if (straps.rom_boot) begin // R05
          state_next = rbl_pkg::ST_ROM_READ; // R08
        end else begin
          state_next = rbl_pkg::ST_EMU_WAIT; // R05
        end
      end
      rbl_pkg::ST_EMU_WAIT: begin
        // The core stays parked until the debugger pin or a release write to the control word lets it go. R06
        if (release_req) begin
          core_stall_next = 1'b0; // R06
          core_start_next = 1'b1;
          done_next = 1'b1;
          state_next = rbl_pkg::ST_RUN;
        end
      end
      rbl_pkg::ST_ROM_READ: begin
        state_next = rbl_pkg::ST_ROM_WAIT;
      end
      rbl_pkg::ST_ROM_WAIT: begin
        if (rd_done) begin
          acc_next = acc_shift; // R09
          raddr_next = raddr_reg + raddr_step;
          part_next = part_reg + 2'h1;
          if (last_part) begin
            part_next = 2'h0;
            state_next = rbl_pkg::ST_WRITE;
          end else begin
            state_next = rbl_pkg::ST_ROM_READ;
          end
        end
      end
      rbl_pkg::ST_WRITE: begin
        // Whole words only reach the destination, in one frame. R10
        dst_we_next = 1'b1;
        dst_addr_next = rbl_pkg::BOOT_DST_ADDR + word_offset; // R08
        dst_data_next = acc_reg;
        copied_next = copied_reg + 1'b1;
        wcnt_next = wcnt_reg + 1'b1;
        if (last_word) begin
          state_next = rbl_pkg::ST_RUN;
          done_next = 1'b1;
          core_stall_next = 1'b0; // R11
          core_start_next = 1'b1; // R11
        end else begin
          state_next = rbl_pkg::ST_ROM_READ; // R10
        end
      end
      rbl_pkg::ST_RUN: begin
        state_next = rbl_pkg::ST_RUN;
      end
      default: begin
        state_next = rbl_pkg::ST_LATCH;
      end
    endcase
  end

  // Every register group returns to its reset value while nrst is low. R04
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= rbl_pkg::ST_LATCH; // R04
    end else begin
      state_reg <= state_next;
    end
  end

  // Reset straps read as little endian, strap high, emulation, 8-bit.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      straps_reg <= rbl_pkg::STRAPS_RST;
    end else begin
      straps_reg <= straps_next; // R14
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      raddr_reg <= rbl_pkg::ROM_START;
      part_reg <= 2'h0;
    end else begin
      raddr_reg <= raddr_next;
      part_reg <= part_next;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      acc_reg <= 32'h0000_0000;
    end else begin
      acc_reg <= acc_next;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wcnt_reg <= '0;
      copied_reg <= '0;
    end else begin
      wcnt_reg <= wcnt_next;
      copied_reg <= copied_next;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= done_next;
    end
  end

  // The core is held stalled from reset onward. R06
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      core_stall <= 1'b1; // R04
    end else begin
      core_stall <= core_stall_next;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      core_start <= 1'b0;
      core_fetch_addr <= rbl_pkg::CORE_START_ADDR;
    end else begin
      core_start <= core_start_next;
      core_fetch_addr <= rbl_pkg::CORE_START_ADDR; // R11
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dst_we <= 1'b0;
    end else begin
      dst_we <= dst_we_next;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dst_addr <= rbl_pkg::BOOT_DST_ADDR;
      dst_data <= 32'h0000_0000;
    end else begin
      dst_addr <= dst_addr_next;
      dst_data <= dst_data_next;
    end
  end

  // Byte order outputs trail the captured straps by one edge.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      big_endian <= 1'b0;
    end else begin
      big_endian <= is_big; // R01
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lane_correct <= 1'b0;
    end else begin
      lane_correct <= is_big && !straps_reg.bus_lane_swap_strap; // R03
    end
  end

endmodule

// file: test/rbl_boot_checker.sv
// Port-level assertions for the reset and boot sequencer.
`timescale 1ns/10ps
module rbl_boot_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Inputs seen
  input wire rbl_pkg::rbl_straps_t straps,
  // Outputs watched
  input wire rbl_pkg::rbl_rom_bus_t rom_bus,
  input wire logic [31:0] dst_addr,
  input wire logic dst_we,
  input wire logic core_stall,
  input wire logic core_start,
  input wire logic [31:0] core_fetch_addr,
  input wire logic big_endian,
  input wire logic lane_correct
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  wire ce_n = rom_bus.chip_select_region_one_n;
  wire big_want = !straps.byte_order_select;
  wire fix_want = big_want && !straps.bus_lane_swap_strap;
  // A short strobe would still pass fast ROMs, so the length is counted.
  logic [4:0] low_cnt;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      low_cnt <= 5'h00;
    else if (ce_n)
      low_cnt <= 5'h00;
    else
      low_cnt <= low_cnt + 5'h01;
  end
  a_rst_stall: assert property (
    $rose(nrst) |-> core_stall && !dst_we && !core_start && ce_n)
    else $error("outputs left the reset state early");
  a_cfg_follow: assert property (
    $rose(nrst) |-> ##2 big_endian == big_want && lane_correct == fix_want)
    else $error("byte order outputs differ from straps");
  a_cfg_hold: assert property (
    nrst && $past(nrst, 3) |-> $stable(big_endian) && $stable(lane_correct))
    else $error("byte order outputs changed after boot start");
  a_strobe_len: assert property (
    $rose(ce_n) |-> low_cnt == 5'(rbl_pkg::ROM_ACC_CYC) && rom_bus.oe_n)
    else $error("ROM strobe length wrong");
  a_addr_stable: assert property (
    !ce_n && $past(!ce_n) |-> $stable(rom_bus.addr))
    else $error("ROM address moved during strobe");
  a_copy_stalled: assert property (
    !ce_n |-> core_stall)
    else $error("ROM read while core running");
  a_word_pulse: assert property (
    dst_we |=> !dst_we)
    else $error("word write longer than one cycle");
  a_dst_align: assert property (
    dst_we |-> dst_addr[1:0] == 2'h0 && dst_addr < 32'h0000_0400)
    else $error("destination address out of image");
  a_start_fall: assert property (
    core_start == $fell(core_stall))
    else $error("start pulse not tied to stall release");
  a_fetch_zero: assert property (
    $fell(core_stall) |-> core_fetch_addr == rbl_pkg::CORE_START_ADDR)
    else $error("core fetch address not zero");
  c_last_word: cover property (dst_we && dst_addr == 32'h0000_03fc);
  c_start: cover property (core_start);
  c_strobe: cover property ($rose(ce_n));
endmodule

bind rbl_boot_ctrl rbl_boot_checker chk_u (.clk(clk), .nrst(nrst),
  .straps(straps), .rom_bus(rom_bus), .dst_addr(dst_addr),
  .dst_we(dst_we), .core_stall(core_stall), .core_start(core_start),
  .core_fetch_addr(core_fetch_addr), .big_endian(big_endian),
  .lane_correct(lane_correct));

// file: test/rbl_rom_model.sv
// Behavioural boot ROM on chip select region one.
`timescale 1ns/10ps
module rbl_rom_model (
  // Clock
  input wire logic clk,
  // System setup
  input wire logic big,
  input wire logic w16,
  input wire logic strap,
  // ROM pins
  input wire rbl_pkg::rbl_rom_bus_t rom_bus,
  output logic [15:0] rom_data
);
  logic [7:0] mem [0:1023];
  logic [15:0] last_q = 16'h0000;
  wire sel = !rom_bus.chip_select_region_one_n && !rom_bus.oe_n;
  wire [7:0] b0 = mem[rom_bus.addr];
  wire [7:0] b1 = mem[rom_bus.addr | 10'h001];
  wire [15:0] half = big ? {b0, b1} : {b1, b0};
  wire [15:0] byt = big && strap ? {b0, ~b0} : {~b0, b0};
  // Released lanes toggle so a late sample never reads old data.
  assign rom_data = !sel ? ~last_q : (w16 ? half : byt);
  always @(posedge clk)
    last_q <= rom_data;
endmodule

// file: test/tb_top.sv
// Self-checking bench for the reset and boot sequencer.
`timescale 1ns/10ps
module tb_top;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  rbl_pkg::rbl_straps_t straps = rbl_pkg::STRAPS_RST;
  rbl_pkg::rbl_straps_t cfg_q = rbl_pkg::STRAPS_RST;
  logic emu_release = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  rbl_pkg::rbl_rom_bus_t rom_bus;
  logic [15:0] rom_data;
  logic [31:0] dst_addr;
  logic [31:0] dst_data;
  logic dst_we;
  logic core_stall;
  logic core_start;
  logic [31:0] core_fetch_addr;
  logic big_endian;
  logic lane_correct;
  int bad_count = 0;
  int samples_checked = 0;
  int words = 0;
  int starts = 0;
  int cyc = 0;
  logic [3:0] tbl [4] = '{4'he, 4'hf, 4'h2, 4'h3};
  rbl_boot_ctrl dut_u (.clk(clk), .nrst(nrst), .straps(straps),
    .emu_release(emu_release), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .rom_bus(rom_bus), .rom_data(rom_data), .dst_addr(dst_addr),
    .dst_data(dst_data), .dst_we(dst_we), .core_stall(core_stall),
    .core_start(core_start), .core_fetch_addr(core_fetch_addr),
    .big_endian(big_endian), .lane_correct(lane_correct));
  rbl_rom_model rom_u (.clk(clk), .big(!cfg_q.byte_order_select),
    .w16(cfg_q.rom_width16), .strap(cfg_q.bus_lane_swap_strap),
    .rom_bus(rom_bus), .rom_data(rom_data));
  always #10 clk = ~clk;
  task results;
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] exp_word(int i);
    logic [7:0] b [4];
    for (int k = 0; k < 4; k++)
      b[k] = rom_u.mem[4 * i + k];
    if (cfg_q.byte_order_select)
      return {b[3], b[2], b[1], b[0]};
    return {b[0], b[1], b[2], b[3]};
  endfunction
  function automatic logic [31:0] exp_st(rbl_pkg::rbl_straps_t c, logic s);
    return {26'h0, c.bus_lane_swap_strap, c.rom_width16, c.rom_boot,
      !c.byte_order_select, !s, s};
  endfunction
  task av(input logic w, input logic [3:0] a, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= 32'h0000_0001;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0 && n < 100) begin
      @(posedge clk);
      n++;
    end
    if (n >= 100)
      chk(32'h1, 32'h0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  always @(posedge clk) begin
    if (dst_we === 1'b1) begin
      chk(dst_addr, 32'(words * 4));
      chk(dst_data, exp_word(words));
      words++;
    end
    if (core_start === 1'b1)
      starts++;
    cyc++;
    if (cyc > 90000) begin
      bad_count++;
      results();
    end
  end
  task run(input rbl_pkg::rbl_straps_t c, input int r);
    logic [31:0] q;
    int n;
    n = 0;
    cfg_q = c;
    nrst <= 1'b0;
    straps <= c;
    repeat (8) @(posedge clk);
    words = 0;
    starts = 0;
    nrst <= 1'b1;
    av(1'b0, rbl_pkg::REG_STATUS, q);
    chk(q & 32'h3f, exp_st(c, 1'b1));
    straps <= 4'($urandom);
    av(1'b0, 4'hc, q);
    chk(q, 32'h0);
    // A release write without its low byte lane must leave the core parked.
    avs_byteenable <= 4'he;
    av(1'b1, rbl_pkg::REG_CTRL, q);
    avs_byteenable <= 4'hf;
    repeat ($urandom_range(40, 5)) @(posedge clk);
    av(1'b0, rbl_pkg::REG_STATUS, q);
    chk(q & 32'h3f, exp_st(c, 1'b1));
    if (c.rom_boot || r[0]) begin
      @(posedge clk);
      // The emulator has set its breakpoint at zero before this release.
      emu_release <= 1'b1;
      @(posedge clk);
      emu_release <= 1'b0;
    end
    if (c.rom_boot || !r[0])
      av(1'b1, rbl_pkg::REG_CTRL, q);
    while (starts == 0 && n < 30000) begin
      @(posedge clk);
      n++;
    end
    chk(32'(starts), 32'h1);
    chk(32'(words), c.rom_boot ? 32'h100 : 32'h0);
    chk(core_fetch_addr, 32'h0);
    av(1'b0, rbl_pkg::REG_STATUS, q);
    chk(q & 32'h3f, exp_st(c, 1'b0));
    av(1'b0, rbl_pkg::REG_COUNT, q);
    chk(q, c.rom_boot ? 32'h100 : 32'h0);
    $display("test %0d done, %0d words", r, words);
  endtask
  initial begin
    logic b;
    void'($urandom(32'h98046468));
    for (int i = 0; i < 1024; i++)
      rom_u.mem[i] = 8'($urandom);
    for (int r = 0; r < 6; r++) begin
      b = 1'($urandom);
      if (r < 4)
        run(tbl[r], r);
      else
        run({b, b, 1'b0, 1'($urandom)}, r);
    end
    results();
  end
endmodule
